/* src/wot_pkg.sv */
// Purpose: constants for the wait one-shot timer
// Assumes: apb slave, 32-bit data, one word per register
// Notes: register map and field positions live here only
// How it works
// RULE1: polarity bit picks active level, idle opposite
// RULE2: software keeps output switch bit zero
// RULE3: pin edge triggers only when enabled
// RULE4: edge select zero falling, one rising
// RULE5: upper four output control bits read zero
// RULE6: counting halted after reset
// RULE7: run clear or stop command reloads, halts
// RULE8: active flag rises after one-two source cycles
// RULE9: active flag falls after one-two source cycles
// RULE10: no other access during start/stop handshake
// RULE11: forced halt stops at once
// RULE12: one-shot flag changes after one-two cycles
// RULE13: opposing one-shot commands may settle either way
// RULE14: neighbour timer must be in counting mode
// RULE15: prescaler writes three source cycles apart
// RULE16: primary writes three prescaler underflows apart
// RULE17: prescaler and counter read as separate bytes
// RULE18: primary underflow loads secondary, secondary ends shot
// RULE19: interrupt request raised at pulse end
// RULE20: stopped writes load counters, running only reloads
// RULE21: source f1, f2, f8 or neighbour underflow
// RULE22: trigger pin synchronised before edge detection
`default_nettype none
package wot_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 8;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OSC  = 8'h04;
  localparam logic [7:0] OFF_IOC  = 8'h08;
  localparam logic [7:0] OFF_MODE = 8'h0C;
  localparam logic [7:0] OFF_PRE  = 8'h10;
  localparam logic [7:0] OFF_SEC  = 8'h14;
  localparam logic [7:0] OFF_PRI  = 8'h18;
  // timer_control_reg fields
  localparam int B_RUN  = 0;
  localparam int B_ACT  = 1;
  localparam int B_HALT = 2;
  // oneshot_control_reg fields
  localparam int B_OS_START = 0;
  localparam int B_OS_STOP  = 1;
  localparam int B_OS_ACT   = 2;
  // pulse_output_control fields
  localparam int B_POL  = 0;
  localparam int B_OSW  = 1;
  localparam int B_PTEN = 2;
  localparam int B_EDGE = 3;
  localparam int IOC_W  = 4;
  // count source select codes
  localparam logic [1:0] SRC_F1 = 2'h0;
  localparam logic [1:0] SRC_F2 = 2'h1;
  localparam logic [1:0] SRC_F8 = 2'h2;
  localparam logic [1:0] SRC_NB = 2'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  // reset values
  localparam logic [IOC_W-1:0] IOC_RST = 4'h0;
  localparam logic [1:0]       SRC_RST = SRC_F1;
  localparam logic [CNT_W-1:0] CNT_RST = 8'hFF;
  localparam logic [DATA_W-1:0] ZERO_W = 32'h0000_0000;
endpackage
`default_nettype wire

/* src/count_if.sv */
// Purpose: link between timer control and one down counter
// Assumes: single clock domain
// Notes: load has priority over decrement
`timescale 1ns/1ps
`default_nettype none
interface count_if #(parameter int W = 8);
  logic         load;
  logic [W-1:0] load_val;
  logic         dec;
  logic [W-1:0] value;
  logic         zero;
  modport ctrl (output load, output load_val, output dec, input value, input zero);
  modport cnt  (input load, input load_val, input dec, output value, output zero);
endinterface
`default_nettype wire

/* src/reload_down_counter.sv */
// Purpose: loadable down counter with zero detect
// Assumes: dec only meaningful when no load
// Notes: wraps below zero; caller reloads on underflow
`timescale 1ns/1ps
`default_nettype none
module reload_down_counter #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // control side
  count_if.cnt      c
);
  import wot_pkg::*;

  logic [W-1:0] value_q;

  // load wins over decrement
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      value_q <= W'(CNT_RST);
    else if (c.load)
      value_q <= c.load_val;
    else if (c.dec)
      value_q <= value_q - W'(1);
  end

  // live count and underflow hint
  assign c.value = value_q;
  assign c.zero  = (value_q == '0);
endmodule
`default_nettype wire

/* src/wait_oneshot_timer.sv */
// Purpose: prescaler plus reload timer in wait one-shot mode
// Assumes: apb master on core_clk; neighbour underflow is a core_clk pulse
// Notes: zero wait state apb; read data sampled in setup cycle
`timescale 1ns/1ps
`default_nettype none
module wait_oneshot_timer (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [wot_pkg::ADDR_W-1:0] paddr,
  input  wire logic [wot_pkg::DATA_W-1:0] pwdata,
  output logic      [wot_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  // trigger and count source inputs
  input  wire logic                       trig_pin,
  input  wire logic                       nb_underflow,
  // outputs
  output logic                            pulse_out_pin,
  output logic                            irq
);
  import wot_pkg::*;

  logic              wr_en;
  logic              hit;
  logic              halt_wr;
  logic              os_start_wr;
  logic              os_stop_wr;
  logic [DATA_W-1:0] rd_d;
  logic [DATA_W-1:0] prdata_q;
  logic              run_q;
  logic [IOC_W-1:0]  ioc_q;
  logic [1:0]        src_q;
  logic [CNT_W-1:0]  pre_rld_q;
  logic [CNT_W-1:0]  sec_rld_q;
  logic [CNT_W-1:0]  pri_rld_q;
  logic [2:0]        div_q;
  logic              tick;
  logic              run_pend_q;
  logic              cnt_act_q;
  logic              pin_s1_q;
  logic              pin_s2_q;
  logic              pin_s3_q;
  logic              pin_edge;
  logic              trig_ev;
  logic              req_v_q;
  logic              req_val_q;
  logic              arm_v_q;
  logic              arm_val_q;
  logic              os_act_q;
  logic              running;
  logic              run_tick;
  logic              pre_uf;
  logic              main_uf;
  logic              phase_q;
  logic              end_ev;
  logic              out_q;
  logic              end_q;
  logic              irq_q;

  count_if #(.W(CNT_W)) pre_c ();
  count_if #(.W(CNT_W)) main_c ();

  // apb decode: access phase writes, always ready
  assign wr_en   = psel & penable & pwrite;
  assign hit     = (paddr[1:0] == 2'h0) && (paddr <= OFF_PRI);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_q;

  // one-cycle command strobes
  // RULE11: forced halt strobe
  assign halt_wr     = wr_en && (paddr == OFF_CTRL) && pwdata[B_HALT];
  assign os_start_wr = wr_en && (paddr == OFF_OSC) && pwdata[B_OS_START];
  assign os_stop_wr  = wr_en && (paddr == OFF_OSC) && pwdata[B_OS_STOP];

  // read mux, sampled in the setup cycle
  always_comb
  begin
    rd_d = ZERO_W;
    case (paddr)
      OFF_CTRL:
      begin
        rd_d[B_RUN] = run_q;
        rd_d[B_ACT] = cnt_act_q;
      end
      OFF_OSC:  rd_d[B_OS_ACT] = os_act_q;
      // RULE5: upper bits stay zero
      OFF_IOC:  rd_d[IOC_W-1:0] = ioc_q;
      OFF_MODE: rd_d[1:0] = src_q;
      // RULE17: each half is its own word
      OFF_PRE:  rd_d[CNT_W-1:0] = pre_c.value;
      OFF_SEC:  rd_d[CNT_W-1:0] = sec_rld_q;
      OFF_PRI:  rd_d[CNT_W-1:0] = main_c.value;
      default:  rd_d = ZERO_W;
    endcase
  end

  // read data register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      prdata_q <= ZERO_W;
    else if (psel && !penable && !pwrite)
      prdata_q <= rd_d;
  end

  // run request; forced halt also drops it
  // RULE6: halted after reset
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      run_q <= 1'b0;
    else if (halt_wr)
      run_q <= 1'b0;
    else if (wr_en && paddr == OFF_CTRL)
      run_q <= pwdata[B_RUN];
  end

  // configuration and reload registers
  // RULE20: reload registers always take writes
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ioc_q     <= IOC_RST;
      src_q     <= SRC_RST;
      pre_rld_q <= CNT_RST;
      sec_rld_q <= CNT_RST;
      pri_rld_q <= CNT_RST;
    end
    else if (wr_en)
    begin
      case (paddr)
        OFF_IOC:  ioc_q     <= pwdata[IOC_W-1:0];
        OFF_MODE: src_q     <= pwdata[1:0];
        OFF_PRE:  pre_rld_q <= pwdata[CNT_W-1:0];
        OFF_SEC:  sec_rld_q <= pwdata[CNT_W-1:0];
        OFF_PRI:  pri_rld_q <= pwdata[CNT_W-1:0];
        default:  ioc_q     <= ioc_q;
      endcase
    end
  end

  // free running divider for f2 and f8
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end

  // count source tick
  // RULE21: source select
  always_comb
  begin
    case (src_q)
      SRC_F1:  tick = 1'b1;
      SRC_F2:  tick = div_q[0];
      SRC_F8:  tick = (div_q == DIV8_LAST);
      SRC_NB:  tick = nb_underflow;
      default: tick = 1'b1;
    endcase
  end

  // start/stop handshake: two source ticks from request to flag
  // RULE8: delayed rise
  // RULE9: delayed fall
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || halt_wr)
    begin
      run_pend_q <= 1'b0;
      cnt_act_q  <= 1'b0;
    end
    else if (tick)
    begin
      run_pend_q <= run_q;
      cnt_act_q  <= run_pend_q;
    end
  end

  // trigger pin synchroniser and edge history
  // RULE22: two stages before edge logic
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= trig_pin;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // RULE4: edge polarity
  assign pin_edge = ioc_q[B_EDGE] ? (pin_s2_q & ~pin_s3_q) : (~pin_s2_q & pin_s3_q);
  // RULE3: pin gated by enable
  assign trig_ev  = os_start_wr | (ioc_q[B_PTEN] & pin_edge);

  // one-shot request pipeline, last command wins
  // RULE13: opposing commands overwrite the pending one
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || halt_wr || !cnt_act_q)
    begin
      req_v_q   <= 1'b0;
      req_val_q <= 1'b0;
    end
    else if (os_stop_wr)
    begin
      req_v_q   <= 1'b1;
      req_val_q <= 1'b0;
    end
    else if (trig_ev)
    begin
      req_v_q   <= 1'b1;
      req_val_q <= 1'b1;
    end
    else if (tick)
      req_v_q <= 1'b0;
  end

  // second stage of the one-shot pipeline
  // RULE12: flag changes on the second tick after the command
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || halt_wr || !cnt_act_q)
    begin
      arm_v_q   <= 1'b0;
      arm_val_q <= 1'b0;
    end
    else if (tick)
    begin
      arm_v_q   <= req_v_q;
      arm_val_q <= req_val_q;
    end
  end

  // one-shot active flag; a start landing with the end wins
  // RULE7: run clear or stop drops the shot
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || halt_wr || !cnt_act_q)
      os_act_q <= 1'b0;
    else if (tick && arm_v_q)
      os_act_q <= arm_val_q;
    else if (end_ev)
      os_act_q <= 1'b0;
  end

  assign running  = cnt_act_q & os_act_q;
  assign run_tick = running & tick;
  assign pre_uf   = run_tick & pre_c.zero;
  assign main_uf  = pre_uf & main_c.zero;
  // RULE18: secondary underflow ends the shot
  assign end_ev   = main_uf & phase_q;

  // counters track reload values while not running
  // RULE7: reload on stop
  // RULE20: stopped writes reach the counters
  assign pre_c.load      = ~running | pre_uf;
  assign pre_c.load_val  = pre_rld_q;
  assign pre_c.dec       = run_tick;
  // RULE18: primary underflow loads secondary
  assign main_c.load     = ~running | main_uf;
  assign main_c.load_val = (running && !phase_q) ? sec_rld_q : pri_rld_q;
  assign main_c.dec      = pre_uf;

  // prescaler counter
  reload_down_counter #(.W(CNT_W)) u_pre (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .c        (pre_c)
  );

  // primary and secondary period counter
  reload_down_counter #(.W(CNT_W)) u_main (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .c        (main_c)
  );

  // period phase: 0 wait, 1 pulse
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !running)
      phase_q <= 1'b0;
    else if (main_uf)
      phase_q <= ~phase_q;
  end

  // pulse pin and interrupt request, both from flops
  // the pulse covers the whole secondary period, the last tick included
  // RULE1: polarity applied to pulse
  // RULE19: request at pulse end
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      out_q <= 1'b0;
      end_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      out_q <= ((running & phase_q) ^ ioc_q[B_POL]);
      end_q <= end_ev; // request lines up with the pin going idle
      irq_q <= end_q;
    end
  end

  assign pulse_out_pin = out_q;
  assign irq           = irq_q;
endmodule
`default_nettype wire

/* test/wait_oneshot_timer_checker.sv */
// Purpose: port-level checks for the wait one-shot timer
// Assumes: zero wait state apb, polarity shadowed from bus writes
// Notes: bound to the top module from the testbench file
`timescale 1ns/1ps
`default_nettype none
module wait_oneshot_timer_checker (
  // clock and reset
  input wire logic                       core_clk,
  input wire logic                       rst_n,
  // apb
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [wot_pkg::ADDR_W-1:0] paddr,
  input wire logic [wot_pkg::DATA_W-1:0] pwdata,
  input wire logic [wot_pkg::DATA_W-1:0] prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // outputs
  input wire logic                       pulse_out_pin,
  input wire logic                       irq
);
  import wot_pkg::*;
  logic acc;
  logic pol_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // access phase
  assign acc = psel && penable;
  // shadow of the polarity bit
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      pol_q <= 1'b0;
    else if (acc && pwrite && paddr == OFF_IOC)
      pol_q <= pwdata[B_POL];
  end
  // bus answers
  a_ready_access: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_bad_addr: assert property (acc && (paddr > OFF_PRI || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access without error");
  a_good_addr: assert property (acc && paddr <= OFF_PRI && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access with error");
  a_ioc_upper: assert property (acc && !pwrite && paddr == OFF_IOC |-> prdata[31:4] == 28'h0)
    else $error("output control upper bits not zero");
  a_cnt_bytes: assert property (acc && !pwrite && (paddr == OFF_PRE || paddr == OFF_PRI)
    |-> prdata[31:8] == 24'h0)
    else $error("counter read wider than a byte");
  // pulse and request
  a_irq_single: assert property (irq |=> !irq)
    else $error("irq longer than one cycle");
  a_irq_end: assert property (irq |-> pulse_out_pin == pol_q && $past(pulse_out_pin) != pol_q)
    else $error("irq not at pulse end");
  a_reset_idle: assert property ($rose(rst_n) |-> !pulse_out_pin && !irq)
    else $error("outputs active after reset");
  a_halt_idle: assert property (acc && pwrite && paddr == OFF_CTRL && pwdata[B_HALT]
    |-> ##2 (pulse_out_pin == pol_q && !irq)[*4])
    else $error("output active after forced halt");
endmodule
`default_nettype wire

/* test/wait_oneshot_timer_tb.sv */
// Purpose: self-checking bench for the wait one-shot timer
// Assumes: zero wait state apb slave, counts run on core_clk
// Notes: reads and pulses are noted in queues and compared by a monitor
`timescale 1ns/1ps
`default_nettype none
module wait_oneshot_timer_tb;
  import wot_pkg::*;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        trig_pin, nb_underflow, pulse_out_pin, irq, pol;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [32:0] eq[$];
  logic [31:0] mq[$];
  int          pq[$];
  int          n_errors, checks_done, cyc, w;
  int          dv[4] = '{1, 2, 8, 4};

  wait_oneshot_timer wait_oneshot_timer_inst (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_pin(trig_pin),
    .nb_underflow(nb_underflow), .pulse_out_pin(pulse_out_pin), .irq(irq)
  );
  // clock
  always #5 core_clk = ~core_clk;
  // neighbour underflow every fourth cycle, cycle ceiling
  always @(posedge core_clk)
  begin
    nb_underflow <= (cyc % 4 == 3);
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // compare each access and each finished pulse with the oldest note
  always @(posedge core_clk)
  begin
    if (rst_n && psel && penable && pready)
      chk({pslverr, prdata & mq.pop_front()}, eq.pop_front());
    if (pulse_out_pin === !pol && pq.size() > 0)
      w++;
    else if (w > 0)
    begin
      chk({irq, 32'(w)}, {1'b1, 32'(pq.pop_front())});
      w = 0;
    end
  end
  // one apb transfer; error expected off the word map
  task automatic apb(input logic wt, input logic [7:0] a, input logic [31:0] d, m);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wt;
    paddr   <= a;
    pwdata  <= d;
    eq.push_back({a > OFF_PRI || a[1:0] != 2'h0, d & m});
    mq.push_back(m);
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (!pready)
      @(posedge core_clk);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] d, m);
    apb(1'b0, a, d, m);
  endtask
  // poll one flag, then note its final value
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    // only the flag word is polled
    do
    begin
      rdc(a, 32'h0, 32'h0);
      n++;
    end while (rd[b] !== v && n < 200);
    rdc(a, 32'(v) << b, 32'h1 << b);
  endtask
  // load a shot and start counting
  task automatic prep(input logic [1:0] src, input logic [7:0] p, s, m, input logic pl);
    wr(OFF_IOC, 32'(pl));
    wr(OFF_MODE, 32'(src));
    wr(OFF_PRE, 32'(p));
    wr(OFF_SEC, 32'(s));
    wr(OFF_PRI, 32'(m));
    rdc(OFF_PRI, 32'(m), 32'hFF);
    wr(OFF_CTRL, 32'h1);
    wait_bit(OFF_CTRL, B_ACT, 1'b1);
    pol = pl;
  endtask
  // shot end reloads primary, then counting stops
  task automatic stop(input logic [7:0] m);
    wait_bit(OFF_OSC, B_OS_ACT, 1'b0);
    rdc(OFF_PRI, 32'(m), 32'hFF);
    wr(OFF_CTRL, 32'h0);
    wait_bit(OFF_CTRL, B_ACT, 1'b0);
  endtask
  // software shot with random counts on one source
  task automatic shot(input int i);
    logic [7:0] p, s, m;
    int t, w0;
    p = 8'($random(seed) & 3);
    s = 8'($random(seed) & 3);
    m = 8'($random(seed) & 3);
    prep(2'(i), p, s, m, i[0]);
    pq.push_back((p + 1) * (s + 1) * dv[i]);
    wr(OFF_OSC, 32'h1);
    t = 0;
    while (pulse_out_pin !== !i[0] && t < 999)
    begin
      @(posedge core_clk);
      t++;
    end
    w0 = (p + 1) * (m + 1) * dv[i];
    chk(33'(t >= w0 && t <= w0 + 3 * dv[i] + 3), 33'h1);
    stop(m);
  endtask
  // main sequence
  initial
  begin
    seed = 32'hb1c5_6f0e;
    {core_clk, rst_n, psel, penable, pwrite, trig_pin, nb_underflow, pol} = 8'h0;
    {paddr, pwdata, n_errors, checks_done, cyc, w} = '0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc(OFF_CTRL, 32'h0, 32'h7);
    rdc(OFF_SEC, 32'hFF, 32'hFF);
    wr(OFF_IOC, 32'hF8);
    rdc(OFF_IOC, 32'h8, 32'hFF);
    rdc(8'h1C, 32'h0, 32'hFFFF_FFFF);
    wr(8'h1A, 32'h1);
    for (int i = 0; i < 4; i++)
      shot(i);
    // pin trigger: disabled edges, wrong edge, then selected edge
    for (int e = 0; e < 2; e++)
    begin
      trig_pin <= e[0];
      prep(SRC_F1, 8'h0, 8'h1, 8'h1, 1'b0);
      trig_pin <= !e[0];
      repeat (8) @(posedge core_clk);
      trig_pin <= e[0];
      repeat (8) @(posedge core_clk);
      rdc(OFF_OSC, 32'h0, 32'h4);
      wr(OFF_IOC, 32'(e * 8 + 4));
      trig_pin <= !e[0];
      repeat (12) @(posedge core_clk);
      rdc(OFF_OSC, 32'h0, 32'h4);
      pq.push_back(2);
      trig_pin <= e[0];
      repeat (12) @(posedge core_clk);
      stop(8'h1);
    end
    // stop command mid-wait reloads
    prep(SRC_F1, 8'h0, 8'h0, 8'hC8, 1'b0);
    wr(OFF_OSC, 32'h1);
    repeat (30) @(posedge core_clk);
    wr(OFF_OSC, 32'h2);
    wait_bit(OFF_OSC, B_OS_ACT, 1'b0);
    rdc(OFF_PRI, 32'hC8, 32'hFF);
    // forced halt on a slow source
    prep(SRC_F8, 8'h0, 8'h0, 8'hC8, 1'b1);
    wr(OFF_OSC, 32'h1);
    repeat (40) @(posedge core_clk);
    wr(OFF_CTRL, 32'h4);
    rdc(OFF_CTRL, 32'h0, 32'h7);
    rdc(OFF_OSC, 32'h0, 32'h4);
    chk(33'(pq.size()), 33'h0);
    wrap_up();
  end
endmodule
bind wait_oneshot_timer wait_oneshot_timer_checker wait_oneshot_timer_checker_inst (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pulse_out_pin(pulse_out_pin), .irq(irq)
);
`default_nettype wire
